// [logic/sds_pkg.sv]
// Constants shared by the step/direction microstep sequencer
// ****************************************************************
// What this block does
// (RULE1) Both-edge bit makes rising and falling pulse edges active, else rising only.
// (RULE2) Pulse and sense inputs are synchronised to the system clock before use.
// (RULE3) Pulse source keeps rate under half clock, or quarter with both edges.
// (RULE4) A 1024-entry sine table spans four full steps, indexed by position.
// (RULE5) Each active edge adds step width when sense is low, subtracts when high.
// (RULE6) Step width is one at finest resolution, doubling per halving, up to 256.
// (RULE7) Resolution may change anytime; coarser moves to nearest valid position.
// (RULE8) Full stepping visits only 128, 384, 640 and 896.
// (RULE9) Coarse positions sit half a step width off the grid origin.
// (RULE10) With interpolation each edge yields 2 to 256 single microsteps; the code yields one at the finest resolution.
// (RULE11) Interpolation runs only while the interpolate enable bit is set.
// (RULE12) Microsteps are spaced evenly over the previous measured pulse period.
// (RULE13) Idle flag sets after 2^20 clocks without edge, 2^18 in quick mode.
// (RULE14) Idle flag clears on the next active edge.
// (RULE15) At standstill the current scale switches from run to hold level.
// (RULE16) With external pulses only hold and run current settings take effect.
// (RULE17) Source should use both edges only with 50% duty and a steady rate.
// (RULE18) New spacing applies after one period; unissued microsteps become a jump.
// (RULE19) Position is ten bits and wraps modulo 1024 both ways.
// ****************************************************************
`default_nettype none
package sds_pkg;
    localparam int unsigned POS_W = 10;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned CUR_W = 5;
    // Register byte offsets
    localparam logic [4:0] OFS_GLOBAL = 5'h00;
    localparam logic [4:0] OFS_CHOPPER = 5'h04;
    localparam logic [4:0] OFS_CURRENT = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    // Field positions
    localparam int unsigned GLB_FAST_BIT = 0;
    localparam int unsigned CHOP_MRES_LSB = 0;
    localparam int unsigned CHOP_INTPOL_BIT = 4;
    localparam int unsigned CHOP_DEDGE_BIT = 5;
    localparam int unsigned CUR_HOLD_LSB = 0;
    localparam int unsigned CUR_RUN_LSB = 8;
    localparam int unsigned STAT_IDLE_BIT = 0;
    localparam int unsigned STAT_POS_LSB = 16;
    localparam int unsigned IRQ_IDLE_BIT = 0;
    localparam int unsigned IRQ_MOVE_BIT = 1;
    // Reset values and the full-step code
    localparam logic [3:0] MRES_RST = 4'h0;
    localparam logic [3:0] MRES_FULL = 4'h8;
    localparam logic [4:0] HOLD_RST = 5'h08;
    localparam logic [4:0] RUN_RST = 5'h10;
    localparam logic [1:0] MASK_RST = 2'h0;
    // Standstill timeouts in system clocks
    localparam int unsigned IDLE_CLKS = 1048576;
    localparam int unsigned IDLE_FAST_CLKS = 262144;
endpackage : sds_pkg
`default_nettype wire

// [logic/sds_wave_if.sv]
// Position and coil current link between sequencer and sine table
`timescale 1ns/1ps
`default_nettype none
interface sds_wave_if;
    logic [9:0] position;
    logic signed [8:0] coilA;
    logic signed [8:0] coilB;
    modport seq (output position, input coilA, input coilB);
    modport lut (input position, output coilA, output coilB);
endinterface : sds_wave_if
`default_nettype wire

// [logic/sds_wave_table.sv]
// Sine table returning both coil currents for a microstep position
`timescale 1ns/1ps
`default_nettype none
module sds_wave_table
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Position in, currents out
    sds_wave_if.lut wave
);
    // ****************************************************************
    // Table contents
    // ****************************************************************
    typedef struct packed {
        logic signed [8:0] a;
        logic signed [8:0] b;
    } sds_wave_state_t;

    sds_wave_state_t state_reg;
    sds_wave_state_t state_next;
    logic signed [8:0] sineMem [0:1023];
    logic [9:0] cosIdx;

    // Rational sine approximation, peak 255, no ROM image needed
    function automatic logic signed [8:0] sine_at(input int idx);
        int x;
        int num;
        int den;
        int val;
        x = idx % 512;
        num = 16 * x * (512 - x) * 255;
        den = 1310720 - 4 * x * (512 - x);
        val = num / den;
        if (idx >= 512)
        begin
            val = -val;
        end
        return 9'(val);
    endfunction : sine_at

    // One entry per position over an electrical turn
    for (genvar i = 0; i < 1024; i++)
    begin : g_sine
        assign sineMem[i] = sine_at(i); // see (RULE4)
    end

    // ****************************************************************
    // Lookup
    // ****************************************************************
    // Coil B leads coil A by a quarter turn, wraps naturally
    assign cosIdx = wave.position + 10'h100;

    always_comb
    begin
        state_next = state_reg;
        state_next.a = sineMem[wave.position]; // see (RULE4)
        state_next.b = sineMem[cosIdx];
    end

    // Registered so the outputs are flop driven
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wave.coilA = state_reg.a;
    assign wave.coilB = state_reg.b;
endmodule : sds_wave_table
`default_nettype wire

// [logic/sds_sequencer.sv]
// Step/direction front end, microstep position counter and register slave
`timescale 1ns/1ps
`default_nettype none
module sds_sequencer
#(
    parameter int unsigned IDLE_CLKS = sds_pkg::IDLE_CLKS,
    parameter int unsigned IDLE_FAST_CLKS = sds_pkg::IDLE_FAST_CLKS
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Motion pulse inputs
    input wire logic stepIn,
    input wire logic dirIn,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Drive outputs
    output logic [9:0] position,
    output logic signed [8:0] coilA,
    output logic signed [8:0] coilB,
    output logic [4:0] currentScale,
    output logic standstill
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic s1Step;
        logic s2Step;
        logic s3Step;
        logic s1Dir;
        logic s2Dir;
        logic [9:0] pos;
        logic [3:0] lastMres;
        logic lastIntpol;
        logic [19:0] periodCnt;
        logic [19:0] interval;
        logic [19:0] tickCnt;
        logic [8:0] remaining;
        logic iDir;
        logic [20:0] idleCnt;
        logic stst;
        logic fast;
        logic [3:0] mres;
        logic intpol;
        logic dedge;
        logic [4:0] hold;
        logic [4:0] run;
        logic [1:0] sticky;
        logic [1:0] mask;
        logic waitReq;
        logic [31:0] readData;
        logic irq;
        logic [4:0] curScale;
    } sds_seq_state_t;

    sds_seq_state_t r;
    sds_seq_state_t n;
    sds_wave_if wave ();

    logic activeEdge;
    logic [9:0] width;
    logic realign;
    logic takeNow;
    logic [20:0] idleLimit;
    logic [1:0] clearMask;
    logic [1:0] events;
    logic [31:0] word;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // Codes above full step give the full-step width
    function automatic logic [9:0] step_width(input logic [3:0] mres);
        logic [3:0] m;
        m = (mres > sds_pkg::MRES_FULL) ? sds_pkg::MRES_FULL : mres;
        return 10'(11'h001 << m); // see (RULE6)
    endfunction : step_width

    // Nearest grid point k*w + w/2 of the given resolution
    function automatic logic [9:0] align_pos(input logic [9:0] pos, input logic [3:0] mres);
        logic [9:0] w;
        w = step_width(mres);
        return (pos & ~(w - 10'h001)) | (w >> 1); // see (RULE7) (RULE9)
    endfunction : align_pos

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ****************************************************************
    // Next state
    // ****************************************************************
    assign width = step_width(r.mres);
    // Edges come from the second and third stages only
    assign activeEdge = (r.s2Step != r.s3Step) && (r.dedge || r.s2Step); // see (RULE1) (RULE2)
    // Leaving interpolation may leave an off-grid position behind
    assign realign = (r.mres != r.lastMres) || (r.lastIntpol && !r.intpol);
    assign takeNow = (read || write) && !r.waitReq;
    assign idleLimit = r.fast ? 21'(IDLE_FAST_CLKS - 1) : 21'(IDLE_CLKS - 1); // see (RULE13)

    always_comb
    begin
        n = r;
        clearMask = 2'h0;
        events = 2'h0;
        word = 32'h0000_0000;
        // Two-stage synchronisers, third stage for the edge
        n.s1Step = stepIn; // see (RULE2)
        n.s2Step = r.s1Step;
        n.s3Step = r.s2Step;
        n.s1Dir = dirIn;
        n.s2Dir = r.s1Dir;
        n.lastMres = r.mres;
        n.lastIntpol = r.intpol;

        // Position: realign beats a coincident edge, which is then lost
        if (realign)
        begin
            n.pos = align_pos(r.pos, r.mres); // see (RULE7)
            n.remaining = 9'h000;
        end
        else if (activeEdge && r.intpol)
        begin
            // Unissued microsteps land at once, then the new pulse starts
            n.pos = r.iDir ? r.pos - 10'(r.remaining) : r.pos + 10'(r.remaining); // see (RULE18)
            n.pos = r.s2Dir ? n.pos - 10'h001 : n.pos + 10'h001; // see (RULE10) (RULE19)
            n.remaining = 9'(width - 10'h001);
            n.iDir = r.s2Dir;
            n.tickCnt = 20'h00000;
        end
        else if (activeEdge)
        begin
            n.pos = r.s2Dir ? r.pos - width : r.pos + width; // see (RULE5) (RULE8) (RULE19)
        end
        else if (r.intpol && r.remaining != 9'h000)
        begin
            // Spacing from the last full period only
            if (r.tickCnt + 20'h00001 >= r.interval)
            begin
                n.tickCnt = 20'h00000;
                n.pos = r.iDir ? r.pos - 10'h001 : r.pos + 10'h001; // see (RULE12)
                n.remaining = r.remaining - 9'h001;
            end
            else
            begin
                n.tickCnt = r.tickCnt + 20'h00001;
            end
        end

        // Period measurement and standstill detection
        if (activeEdge)
        begin
            n.periodCnt = 20'h00000;
            n.interval = ((r.periodCnt >> r.mres) == 20'h00000) ? 20'h00001 : (r.periodCnt >> r.mres); // see (RULE12)
            n.idleCnt = 21'h000000;
            n.stst = 1'b0; // see (RULE14)
        end
        else
        begin
            // Saturate so very slow pulses give the longest spacing
            if (r.periodCnt != 20'hFFFFF)
            begin
                n.periodCnt = r.periodCnt + 20'h00001;
            end
            if (!r.stst)
            begin
                if (r.idleCnt >= idleLimit)
                begin
                    n.stst = 1'b1; // see (RULE13)
                end
                else
                begin
                    n.idleCnt = r.idleCnt + 21'h000001;
                end
            end
        end

        // Bus: one wait cycle, then completion on the low cycle
        if ((read || write) && r.waitReq)
        begin
            n.waitReq = 1'b0;
            case (address)
                sds_pkg::OFS_GLOBAL: n.readData = 32'(r.fast) << sds_pkg::GLB_FAST_BIT;
                sds_pkg::OFS_CHOPPER: n.readData = (32'(r.mres) << sds_pkg::CHOP_MRES_LSB)
                    | (32'(r.intpol) << sds_pkg::CHOP_INTPOL_BIT) | (32'(r.dedge) << sds_pkg::CHOP_DEDGE_BIT);
                sds_pkg::OFS_CURRENT: n.readData = (32'(r.hold) << sds_pkg::CUR_HOLD_LSB)
                    | (32'(r.run) << sds_pkg::CUR_RUN_LSB);
                sds_pkg::OFS_STATUS: n.readData = (32'(r.stst) << sds_pkg::STAT_IDLE_BIT)
                    | (32'(r.pos) << sds_pkg::STAT_POS_LSB);
                sds_pkg::OFS_IRQ_STATUS: n.readData = 32'(r.sticky);
                sds_pkg::OFS_IRQ_MASK: n.readData = 32'(r.mask);
                default: n.readData = 32'h0000_0000;
            endcase
        end
        else
        begin
            n.waitReq = 1'b1;
        end

        // Writes take effect on the completing edge; unmapped ignored
        if (takeNow && write)
        begin
            case (address)
                sds_pkg::OFS_GLOBAL:
                begin
                    word = merge(32'(r.fast), writedata, byteenable);
                    n.fast = word[sds_pkg::GLB_FAST_BIT];
                end
                sds_pkg::OFS_CHOPPER:
                begin
                    word = merge({26'h0, r.dedge, r.intpol, r.mres}, writedata, byteenable);
                    n.mres = word[sds_pkg::CHOP_MRES_LSB +: 4];
                    n.intpol = word[sds_pkg::CHOP_INTPOL_BIT]; // see (RULE11)
                    n.dedge = word[sds_pkg::CHOP_DEDGE_BIT];
                end
                sds_pkg::OFS_CURRENT:
                begin
                    word = merge({19'h0, r.run, 3'h0, r.hold}, writedata, byteenable);
                    n.hold = word[sds_pkg::CUR_HOLD_LSB +: 5];
                    n.run = word[sds_pkg::CUR_RUN_LSB +: 5];
                end
                sds_pkg::OFS_IRQ_MASK:
                begin
                    word = merge(32'(r.mask), writedata, byteenable);
                    n.mask = word[1:0];
                end
                default:
                begin
                    word = 32'h0000_0000;
                end
            endcase
        end

        // Read clears only what was reported; a new event wins
        if (takeNow && read && address == sds_pkg::OFS_IRQ_STATUS)
        begin
            clearMask = r.readData[1:0];
        end
        events[sds_pkg::IRQ_IDLE_BIT] = n.stst && !r.stst;
        events[sds_pkg::IRQ_MOVE_BIT] = r.stst && !n.stst;
        n.sticky = (r.sticky & ~clearMask) | events;
        n.irq = |(n.sticky & n.mask);
        // Only hold and run levels steer the coil scale
        n.curScale = n.stst ? n.hold : n.run; // see (RULE15) (RULE16)
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.mres <= sds_pkg::MRES_RST;
            r.lastMres <= sds_pkg::MRES_RST;
            r.hold <= sds_pkg::HOLD_RST;
            r.run <= sds_pkg::RUN_RST;
            r.curScale <= sds_pkg::RUN_RST;
            r.mask <= sds_pkg::MASK_RST;
            r.interval <= 20'h00001;
            r.waitReq <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // Sine lookup, registered inside the table
    assign wave.position = r.pos;
    sds_wave_table u_table
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .wave(wave.lut)
    );

    assign readdata = r.readData;
    assign waitrequest = r.waitReq;
    assign irq = r.irq;
    assign position = r.pos;
    assign coilA = wave.coilA;
    assign coilB = wave.coilB;
    assign currentScale = r.curScale;
    assign standstill = r.stst;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_single_edge;
        @(posedge mclk) disable iff (!rst_b)
        (!r.dedge && !r.intpol && !realign && r.s3Step && !r.s2Step) |=> (r.pos == $past(r.pos));
    endproperty
    a_single_edge: assert property (p_single_edge) else $error("falling edge moved position"); // see (RULE1)

    property p_sync_edge;
        @(posedge mclk) disable iff (!rst_b)
        activeEdge |-> ($past(stepIn, 2) != $past(stepIn, 3));
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("edge not from synchronised input"); // see (RULE2)

    property p_step_up;
        @(posedge mclk) disable iff (!rst_b)
        (activeEdge && !r.intpol && !realign && !r.s2Dir) |=> (r.pos == 10'($past(r.pos) + $past(width)));
    endproperty
    a_step_up: assert property (p_step_up) else $error("forward step width wrong"); // see (RULE5)

    property p_step_down;
        @(posedge mclk) disable iff (!rst_b)
        (activeEdge && !r.intpol && !realign && r.s2Dir) |=> (r.pos == 10'($past(r.pos) - $past(width)));
    endproperty
    a_step_down: assert property (p_step_down) else $error("reverse step width wrong"); // see (RULE5)

    property p_full_grid;
        @(posedge mclk) disable iff (!rst_b)
        (!r.intpol && !r.lastIntpol && r.mres == 4'h8 && r.lastMres == 4'h8) |-> (r.pos[7:0] == 8'h80);
    endproperty
    a_full_grid: assert property (p_full_grid) else $error("full step off grid"); // see (RULE8)

    property p_interp_load;
        @(posedge mclk) disable iff (!rst_b)
        (activeEdge && r.intpol && !realign) |=> (r.remaining == 9'($past(width) - 10'h001));
    endproperty
    a_interp_load: assert property (p_interp_load) else $error("microstep count not loaded"); // see (RULE10)

    property p_idle_set;
        @(posedge mclk) disable iff (!rst_b)
        (!r.stst && !activeEdge && r.idleCnt >= idleLimit) |=> (r.stst && r.sticky[0]);
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag missed timeout"); // see (RULE13)

    property p_idle_clear;
        @(posedge mclk) disable iff (!rst_b)
        (r.stst && activeEdge) |=> (!r.stst ##0 r.sticky[1]);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle flag not cleared by edge"); // see (RULE14)

    property p_hold_scale;
        @(posedge mclk) disable iff (!rst_b)
        r.stst |-> (r.curScale == r.hold);
    endproperty
    a_hold_scale: assert property (p_hold_scale) else $error("hold current not selected"); // see (RULE15)

    property p_one_wait;
        @(posedge mclk) disable iff (!rst_b)
        !r.waitReq |=> r.waitReq;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest low too long");
endmodule : sds_sequencer
`default_nettype wire

// [sim/sds_step_source.sv]
// Motion controller model driving the pulse and rotation sense lines
`timescale 1ns/1ps
`default_nettype none
module sds_step_source
(
    // Clock
    input wire logic mclk,
    // Pulse outputs
    output logic stepOut,
    output logic dirOut
);
    // Both lines idle low
    initial stepOut = 1'b0;
    initial dirOut = 1'b0;

    // Sense settles a clock ahead of the edge; lo of zero leaves the line high
    task automatic pulse(input logic d, input int hi, input int lo);
        @(posedge mclk);
        dirOut <= d;
        @(posedge mclk);
        stepOut <= 1'b1;
        repeat (hi) @(posedge mclk);
        if (lo > 0)
            stepOut <= 1'b0;
        repeat (lo) @(posedge mclk);
    endtask : pulse
endmodule : sds_step_source
`default_nettype wire

// [sim/step_dir_microstep_sequencer_bench.sv]
// Self-checking bench for the step/direction microstep sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module step_dir_microstep_sequencer_bench;
    // ****************************************************************
    // Signals and reference model state
    // ****************************************************************
    logic mclk, rst_b, stepIn, dirIn, read, write, waitrequest, irq, standstill;
    logic [4:0] address, currentScale;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable, mres;
    logic [9:0] position, mid;
    logic signed [8:0] coilA, coilB;
    int miscompares = 0;
    int totalChecks = 0;
    int modelPos = 0;
    int w = 1;
    int seed = 32'h7727;

    // Short idle limits keep the run brief
    sds_sequencer #(.IDLE_CLKS(64), .IDLE_FAST_CLKS(16)) DUT (.mclk(mclk), .rst_b(rst_b),
        .stepIn(stepIn), .dirIn(dirIn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .position(position), .coilA(coilA),
        .coilB(coilB), .currentScale(currentScale), .standstill(standstill));
    sds_step_source src (.mclk(mclk), .stepOut(stepIn), .dirOut(dirIn));

    // Free-running clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ****************************************************************
    // Bus, step and closing tasks
    // ****************************************************************
    // Request held until waitrequest is sampled low
    task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        // Only the watchdog ends a wait that never completes
        do
        begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : busXfer

    // One pulse of k active edges, model moves k widths
    task automatic step(input logic d, input int h, input int k);
        src.pulse(d, h, h);
        modelPos = (d ? modelPos - w * k : modelPos + w * k) & 1023;
        @(negedge mclk);
        `CHK("position", modelPos[9:0], position)
    endtask : step

    // Resolution write realigns to the nearest grid point
    task automatic setRes(input logic [3:0] m, input logic [1:0] f);
        busXfer(1'b1, 5'h04, {26'h0, f, m});
        w = 1 << (m > 8 ? 8 : m);
        modelPos = (modelPos & ~(w - 1)) | (w / 2);
        repeat (2) @(negedge mclk);
        `CHK("realign", modelPos[9:0], position)
    endtask : setRes

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Watchdog cuts a hang short
    initial
    begin
        #400000;
        miscompares++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        busXfer(1'b0, 5'h08, 32'h0);
        `CHK("current reset", 32'h00001008, rd)
        busXfer(1'b0, 5'h1C, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        // Random resolutions and directions, wrapping freely
        repeat (14)
        begin
            mres = 4'($unsigned($random(seed)) % 9);
            setRes(mres, 2'b00);
            repeat (3) step(1'($random(seed)), 3, 1);
            if (mres == 4'h8)
            begin
                `CHK("full grid", 10'h080, position & 10'h0FF)
                `CHK("coil equal", 1'b1, coilA == coilB || coilA == -coilB)
            end
        end
        // Falling edges count only in both-edge mode
        setRes(4'h0, 2'b10);
        step(1'b0, 3, 2);
        setRes(4'h0, 2'b00);
        step(1'b1, 3, 1);
        // Standstill entry and exit with interrupt
        busXfer(1'b1, 5'h14, 32'h3);
        busXfer(1'b0, 5'h10, 32'h0);
        repeat (70) @(negedge mclk);
        `CHK("standstill", 1'b1, standstill)
        `CHK("hold scale", 5'h08, currentScale)
        `CHK("irq set", 1'b1, irq)
        busXfer(1'b0, 5'h10, 32'h0);
        `CHK("irq entered", 32'h1, rd)
        step(1'b0, 3, 1);
        `CHK("standstill left", 1'b0, standstill)
        `CHK("run scale", 5'h10, currentScale)
        busXfer(1'b0, 5'h10, 32'h0);
        `CHK("irq left", 32'h2, rd)
        repeat (2) @(negedge mclk);
        `CHK("irq clear", 1'b0, irq)
        // Quick standstill limit
        busXfer(1'b1, 5'h00, 32'h1);
        step(1'b0, 3, 1);
        repeat (4) @(negedge mclk);
        `CHK("quick early", 1'b0, standstill)
        repeat (12) @(negedge mclk);
        `CHK("quick idle", 1'b1, standstill)
        busXfer(1'b1, 5'h00, 32'h0);
        // Interpolation spreads sixteen microsteps over the measured period
        setRes(4'h4, 2'b01);
        repeat (3) src.pulse(1'b0, 20, 20);
        @(negedge mclk);
        modelPos = (modelPos + 48) & 1023;
        `CHK("interp", modelPos[9:0], position)
        src.pulse(1'b0, 5, 0);
        @(negedge mclk);
        mid = position - modelPos[9:0];
        `CHK("interp spread", 1'b1, mid > 0 && mid < 16)
        src.pulse(1'b0, 15, 20);
        modelPos = (modelPos + 16) & 1023;
        `CHK("interp done", modelPos[9:0], position)
        // Faster pulse lands the unissued microsteps at once
        src.pulse(1'b0, 4, 4);
        src.pulse(1'b0, 3, 0);
        @(negedge mclk);
        `CHK("interp jump", 10'(modelPos + 17), position)
        src.pulse(1'b0, 1, 20);
        modelPos = (modelPos + 32) & 1023;
        `CHK("interp rest", modelPos[9:0], position)
        setRes(4'h4, 2'b00);
        step(1'b1, 3, 1);
        end_of_test();
    end
endmodule : step_dir_microstep_sequencer_bench
`default_nettype wire
